/* pkg/adcc_pkg.sv */
/*
 * Shared constants for the converter control/result block and its processor-side master.
 * Assumes byte-wide registers at fixed 8-bit addresses and a single 125 MHz clock.
 */
package adcc_pkg;

    // register offsets
    localparam logic [7:0] ADCC_CONVERTER_CONTROL_STATUS = 8'h34;
    localparam logic [7:0] ADCC_RESULT_UPPER_BYTE = 8'h35;
    localparam logic [7:0] ADCC_RESULT_LOWER_AND_CLOCK_SELECT = 8'h36;

    // control/status field positions
    localparam int ADCC_EOC_BIT = 7;
    localparam int ADCC_SPEED_BIT = 6;
    localparam int ADCC_ON_BIT = 5;
    localparam int ADCC_SEL_LSB = 0;
    localparam int ADCC_SEL_MSB = 2;
    // lower result register field positions
    localparam int ADCC_SLOW_BIT = 3;

    // writable masks, reserved bits dropped
    localparam logic [7:0] ADCC_CSR_WRITE_MASK = 8'h67;
    localparam logic [7:0] ADCC_DRL_WRITE_MASK = 8'h08;

    // values after reset
    localparam logic [7:0] ADCC_RESET_BYTE = 8'h00;
    localparam logic [9:0] ADCC_RESET_RESULT = 10'h000;

    // conversion timing in converter clock ticks
    localparam int ADCC_SAMPLE_TICKS = 4;
    localparam int ADCC_BIT_TICKS = 4;
    localparam int ADCC_RESULT_BITS = 10;

    // settle time after wakeup from halt
    localparam int ADCC_SETTLE_NS = 10000;
    localparam int ADCC_CLOCK_PERIOD_NS = 8;
    localparam int ADCC_SETTLE_CYCLES = (ADCC_SETTLE_NS + ADCC_CLOCK_PERIOD_NS - 1)
        / ADCC_CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        ADCC_CMD_WRITE,
        ADCC_CMD_READ8,
        ADCC_CMD_READ10,
        ADCC_CMD_READ
    } adcc_cmd_t;

endpackage : adcc_pkg

/* pkg/adcc_bus_if.sv */
/*
 * Register access carrier between processor-side master and converter block.
 * Assumes both ends share one clock; read data follows a read strobe by one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

interface adcc_bus_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev (input addr, input wr, input rd, input wdata, output rdata);
    modport cpu (output addr, output wr, output rd, output wdata, input rdata);
endinterface : adcc_bus_if

`default_nettype wire

/* rtl/adcc_device.sv */
/*
 * Converter control and result logic: registers, clock divider, successive approximation.
 * Assumes an external analog comparator (input >= trial code) and a processor-side master.
 */
//
// Overview of operation
// R01: above upper reference gives full-scale code
// R02: below lower reference gives zero code
// R03: three-bit field routes inputs zero to six
// R04: converter on starts continuous conversion
// R05: each completion stores result, sets flag
// R06: upper result read clears the flag
// R07: ten bits: poll, read lower, upper
// R08: eight bits: poll, then read upper
// R09: converter off while on bit clear
// R10: processor wait mode changes nothing
// R11: halt disables; wait settle after wakeup
// R12: slow/speed bits pick divide 2/1/4
// R13: software writes zeros to reserved bits
// R14: lower register reserved bits read zero
// R15: upper register holds result bits 9:2
// R16: lower register: result 1:0, slow bit
// R17: reset clears all three registers
// R18: analog use leaves digital read intact
// R19: conversion length parameter; results overwrite
`timescale 1ns/100ps
`default_nettype none

module adcc_device import adcc_pkg::*; #(
    parameter int SAMPLE_TICKS = ADCC_SAMPLE_TICKS,
    parameter int BIT_TICKS = ADCC_BIT_TICKS
) (
    input wire logic i_clock,
    input wire logic i_rst,
    adcc_bus_if.dev bus,
    input wire logic i_comparator,
    input wire logic i_halt,
    output logic o_converter_power,
    output logic [2:0] o_input_select,
    output logic [9:0] o_dac_code,
    output logic o_sample
);

    typedef enum logic [1:0] {ADCC_OFF, ADCC_SAMPLING, ADCC_TRIAL} adcc_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic eoc;
    logic speed;
    logic converter_on;
    logic [2:0] input_select;
    logic slow;
    logic [9:0] result;
    logic [9:0] dac;
    logic [3:0] bit_idx;
    logic [7:0] tick_cnt;
    logic [1:0] div_cnt;
    logic comp_meta;
    logic comp_sync;
    logic halt_meta;
    logic halt_sync;
    logic [7:0] rdata;
    adcc_state_t state;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire active = converter_on && !halt_sync; // R09 R11 R10
    wire wr_csr = bus.wr && (bus.addr == ADCC_CONVERTER_CONTROL_STATUS);
    wire wr_drl = bus.wr && (bus.addr == ADCC_RESULT_LOWER_AND_CLOCK_SELECT);
    wire rd_drh = bus.rd && (bus.addr == ADCC_RESULT_UPPER_BYTE);
    wire adc_tick = slow ? (div_cnt == 2'h3) : (speed ? 1'b1 : div_cnt[0]); // R12
    wire sample_last = (tick_cnt == 8'(SAMPLE_TICKS - 1));
    wire bit_last = (tick_cnt == 8'(BIT_TICKS - 1));
    wire [9:0] bit_mask = 10'h001 << bit_idx;
    wire [9:0] decided = trial_keep(comp_sync, dac, bit_mask); // R01 R02
    wire done = active && adc_tick && (state == ADCC_TRIAL) && bit_last && (bit_idx == 4'h0);
    wire [7:0] csr_view = {eoc, speed, converter_on, 2'h0, input_select};
    wire [7:0] drh_view = result[9:2]; // R15
    wire [7:0] drl_view = {4'h0, slow, 1'b0, result[1:0]}; // R14 R16
    wire [7:0] next_rdata = (bus.addr == ADCC_CONVERTER_CONTROL_STATUS) ? csr_view :
                            (bus.addr == ADCC_RESULT_UPPER_BYTE) ? drh_view :
                            (bus.addr == ADCC_RESULT_LOWER_AND_CLOCK_SELECT) ? drl_view :
                            ADCC_RESET_BYTE;

    function automatic logic [9:0] trial_keep(input logic keep, input logic [9:0] code,
                                              input logic [9:0] mask);
        trial_keep = keep ? code : (code & ~mask);
    endfunction : trial_keep

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers for comparator and halt

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else begin
            comp_meta <= i_comparator;
            comp_sync <= comp_meta;
            halt_meta <= i_halt;
            halt_sync <= halt_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            speed <= 1'b0; // R17
            converter_on <= 1'b0; // R17
            input_select <= 3'h0; // R17
            slow <= 1'b0; // R17
        end else begin
            if (wr_csr) begin
                speed <= bus.wdata[ADCC_SPEED_BIT];
                converter_on <= bus.wdata[ADCC_ON_BIT]; // R04
                input_select <= bus.wdata[ADCC_SEL_MSB:ADCC_SEL_LSB]; // R03
            end
            if (wr_drl) begin
                slow <= bus.wdata[ADCC_SLOW_BIT]; // R12
            end
        end
    end

    // completion flag, set wins over read clear
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            eoc <= 1'b0;
        end else if (done) begin
            eoc <= 1'b1; // R05
        end else if (rd_drh) begin
            eoc <= 1'b0; // R06
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata <= ADCC_RESET_BYTE;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider and successive approximation

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_cnt <= 2'h0;
        end else if (!active) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= ADCC_OFF;
            tick_cnt <= 8'h00;
            bit_idx <= 4'h0;
            dac <= ADCC_RESET_RESULT;
            result <= ADCC_RESET_RESULT; // R17
        end else if (!active) begin
            state <= ADCC_OFF; // R09 R11
            tick_cnt <= 8'h00;
            dac <= ADCC_RESET_RESULT;
        end else if (adc_tick) begin
            unique case (state)
                ADCC_OFF: begin
                    state <= ADCC_SAMPLING; // R04
                    tick_cnt <= 8'h00;
                end
                ADCC_SAMPLING: begin
                    if (sample_last) begin
                        state <= ADCC_TRIAL;
                        tick_cnt <= 8'h00;
                        bit_idx <= 4'(ADCC_RESULT_BITS - 1);
                        dac <= 10'h200;
                    end else begin
                        tick_cnt <= tick_cnt + 8'h01;
                    end
                end
                ADCC_TRIAL: begin
                    if (!bit_last) begin
                        tick_cnt <= tick_cnt + 8'h01;
                    end else if (bit_idx == 4'h0) begin
                        result <= decided; // R05 R19
                        state <= ADCC_SAMPLING; // R04
                        tick_cnt <= 8'h00;
                    end else begin
                        dac <= decided | (bit_mask >> 1);
                        bit_idx <= bit_idx - 4'h1;
                        tick_cnt <= 8'h00;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops; port pins are only observed, never driven

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_converter_power <= 1'b0;
            o_input_select <= 3'h0;
            o_dac_code <= ADCC_RESET_RESULT;
            o_sample <= 1'b0;
        end else begin
            o_converter_power <= active; // R09 R18
            o_input_select <= input_select; // R03
            o_dac_code <= dac;
            o_sample <= active && (state == ADCC_SAMPLING);
        end
    end

    assign bus.rdata = rdata;

endmodule : adcc_device

`default_nettype wire

/* rtl/adcc_host.sv */
/*
 * Processor-side master: register writes, flag polling and ordered result reads.
 * Assumes the converter block answers a read strobe with data one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none

module adcc_host import adcc_pkg::*; #(
    parameter int SETTLE_CYCLES = ADCC_SETTLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    adcc_bus_if.cpu bus,
    input wire logic i_cmd_valid,
    input wire adcc_cmd_t i_cmd,
    input wire logic [7:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_halt,
    output logic o_cmd_ready,
    output logic o_result_valid,
    output logic [9:0] o_result,
    output logic o_settled
);

    typedef enum logic [2:0] {
        ADCC_IDLE, ADCC_POLL, ADCC_POLL_WAIT, ADCC_LOW_WAIT, ADCC_HIGH, ADCC_HIGH_WAIT,
        ADCC_READ_WAIT
    } adcc_hstate_t;

    adcc_hstate_t state;
    logic ten_bits;
    logic [1:0] low_bits;
    logic [31:0] settle_cnt;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    // high in the cycle the answer to a read strobe stands on rdata
    logic rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire take = (state == ADCC_IDLE) && i_cmd_valid;
    wire settled = (settle_cnt == 32'(SETTLE_CYCLES));
    wire [7:0] csr_write = i_cmd_data & ADCC_CSR_WRITE_MASK; // R13
    wire [7:0] drl_write = i_cmd_data & ADCC_DRL_WRITE_MASK; // R13
    wire [7:0] masked = (i_cmd_addr == ADCC_CONVERTER_CONTROL_STATUS) ? csr_write :
                        (i_cmd_addr == ADCC_RESULT_LOWER_AND_CLOCK_SELECT) ? drl_write :
                        i_cmd_data;
    wire eoc_seen = bus.rdata[ADCC_EOC_BIT] && settled;

    ////////////////////////////////////////////////////////////////////////////
    // settle counter after halt

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            settle_cnt <= 32'h00000000;
        end else if (i_halt) begin
            settle_cnt <= 32'h00000000; // R11
        end else if (!settled) begin
            settle_cnt <= settle_cnt + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= ADCC_IDLE;
            ten_bits <= 1'b0;
            low_bits <= 2'h0;
            addr <= 8'h00;
            wr <= 1'b0;
            rd <= 1'b0;
            rd_q <= 1'b0;
            wdata <= 8'h00;
            o_result_valid <= 1'b0;
            o_result <= ADCC_RESET_RESULT;
        end else begin
            wr <= 1'b0;
            rd <= 1'b0;
            rd_q <= rd;
            o_result_valid <= 1'b0;
            unique case (state)
                ADCC_IDLE: begin
                    if (take) begin
                        ten_bits <= (i_cmd == ADCC_CMD_READ10);
                        addr <= i_cmd_addr;
                        unique case (i_cmd)
                            ADCC_CMD_WRITE: begin
                                wr <= 1'b1;
                                wdata <= masked;
                            end
                            ADCC_CMD_READ: begin
                                rd <= 1'b1;
                                state <= ADCC_READ_WAIT;
                            end
                            ADCC_CMD_READ8, ADCC_CMD_READ10: begin
                                state <= ADCC_POLL;
                            end
                        endcase
                    end
                end
                ADCC_POLL: begin
                    addr <= ADCC_CONVERTER_CONTROL_STATUS;
                    rd <= 1'b1; // R07 R08
                    state <= ADCC_POLL_WAIT;
                end
                ADCC_POLL_WAIT: begin
                    if (!rd_q) begin
                        state <= ADCC_POLL_WAIT;
                    end else if (!eoc_seen) begin
                        state <= ADCC_POLL;
                    end else if (ten_bits) begin
                        addr <= ADCC_RESULT_LOWER_AND_CLOCK_SELECT;
                        rd <= 1'b1; // R07
                        state <= ADCC_LOW_WAIT;
                    end else begin
                        state <= ADCC_HIGH; // R08
                    end
                end
                ADCC_LOW_WAIT: begin
                    if (rd_q) begin
                        low_bits <= bus.rdata[1:0];
                        state <= ADCC_HIGH;
                    end
                end
                ADCC_HIGH: begin
                    addr <= ADCC_RESULT_UPPER_BYTE;
                    rd <= 1'b1; // R07 R08
                    state <= ADCC_HIGH_WAIT;
                end
                ADCC_HIGH_WAIT: begin
                    if (rd_q) begin
                        o_result <= ten_bits ? {bus.rdata, low_bits} : {2'h0, bus.rdata};
                        o_result_valid <= 1'b1;
                        state <= ADCC_IDLE;
                    end
                end
                ADCC_READ_WAIT: begin
                    if (rd_q) begin
                        o_result <= {2'h0, bus.rdata};
                        o_result_valid <= 1'b1;
                        state <= ADCC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_cmd_ready <= 1'b0;
            o_settled <= 1'b0;
        end else begin
            o_cmd_ready <= (state == ADCC_IDLE) && !take && !o_result_valid;
            o_settled <= settled;
        end
    end

    assign bus.addr = addr;
    assign bus.wr = wr;
    assign bus.rd = rd;
    assign bus.wdata = wdata;

endmodule : adcc_host

`default_nettype wire

/* tb/adcc_bus_sva.sv */
/*
 * Checker for the register bus between the host master and the converter block.
 * Assumes one clock shared by both ends and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module adcc_bus_sva import adcc_pkg::*; (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    logic [7:0] csr_wr;
    logic slow_wr;
    logic rd_csr_q;
    logic eoc_seen;
    wire csr_rd = rd && addr == ADCC_CONVERTER_CONTROL_STATUS;
    wire upr_rd = rd && addr == ADCC_RESULT_UPPER_BYTE;
    wire drl_rd = rd && addr == ADCC_RESULT_LOWER_AND_CLOCK_SELECT;
    wire map_hit = addr >= ADCC_CONVERTER_CONTROL_STATUS && addr <= 8'h36;
    wire eoc_now = rd_csr_q && rdata[ADCC_EOC_BIT];

    ////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            csr_wr <= 8'h00;
            slow_wr <= 1'b0;
            rd_csr_q <= 1'b0;
            eoc_seen <= 1'b0;
        end else begin
            rd_csr_q <= csr_rd;
            eoc_seen <= upr_rd ? 1'b0 : (eoc_seen || eoc_now);
            if (wr && addr == ADCC_CONVERTER_CONTROL_STATUS) begin
                csr_wr <= wdata & ADCC_CSR_WRITE_MASK;
            end
            if (wr && addr == ADCC_RESULT_LOWER_AND_CLOCK_SELECT) begin
                slow_wr <= wdata[ADCC_SLOW_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    sequence s_upper;
        upr_rd;
    endsequence
    sequence s_csr;
        csr_rd;
    endsequence
    property p_csr_write_reserved;
        wr && addr == ADCC_CONVERTER_CONTROL_STATUS |-> wdata[4:3] == 2'b00;
    endproperty
    property p_csr_readback;
        s_csr |=> (rdata & 8'h7F) == $past(csr_wr);
    endproperty
    property p_drl_reserved;
        drl_rd |=> rdata[7:4] == 4'h0 && !rdata[2];
    endproperty
    property p_slow_readback;
        drl_rd |=> rdata[ADCC_SLOW_BIT] == $past(slow_wr);
    endproperty
    property p_unmapped;
        rd && !map_hit |=> rdata == 8'h00;
    endproperty
    property p_upper_after_poll;
        s_upper |-> eoc_seen || eoc_now;
    endproperty
    property p_eoc_clear;
        s_upper ##[1:20] s_csr |=> !rdata[ADCC_EOC_BIT];
    endproperty
    property p_rdata_hold;
        !rd |=> $stable(rdata);
    endproperty

    a_csr_write_reserved: assert property (p_csr_write_reserved)
        else $error("reserved control bits written nonzero");
    a_csr_readback: assert property (p_csr_readback)
        else $error("control readback differs from write");
    a_drl_reserved: assert property (p_drl_reserved)
        else $error("lower register reserved bits nonzero");
    a_slow_readback: assert property (p_slow_readback)
        else $error("slow bit readback differs");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read nonzero");
    a_upper_after_poll: assert property (p_upper_after_poll)
        else $error("upper read without completed poll");
    a_eoc_clear: assert property (p_eoc_clear)
        else $error("flag not cleared by upper read");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");
endmodule : adcc_bus_sva

`default_nettype wire

/* tb/adc_control_result_logic_test.sv */
/*
 * Testbench: host and converter joined by one carrier, a second converter driven by tasks.
 * Assumes a behavioural comparator: input level at or above the trial code.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_control_result_logic_test import adcc_pkg::*;;
    localparam int SETTLE = 4;
    localparam logic [7:0] CSR = ADCC_CONVERTER_CONTROL_STATUS;
    localparam logic [7:0] UPR = ADCC_RESULT_UPPER_BYTE;
    localparam logic [7:0] DRL = ADCC_RESULT_LOWER_AND_CLOCK_SELECT;
    localparam logic [9:0] LVL [8] = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A, 10'h001, 10'h200,
        10'h1FF, 10'h000};
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic halt = 1'b0;
    logic cmd_valid = 1'b0;
    adcc_cmd_t cmd = ADCC_CMD_WRITE;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, res_valid, settled, pwr_a, pwr_b, smp_a;
    logic [9:0] res, dac_a, dac_b, r;
    logic [2:0] sel_a, sel_b;
    logic [7:0] v;
    logic slow, spd;
    int fail_count = 0;
    int tests_run = 0;
    int n, len, div;
    adcc_bus_if bus_a();
    adcc_bus_if bus_b();

    always #4 i_clock = ~i_clock;

    adcc_device i_adcc_device (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_a.dev),
        .i_comparator(LVL[sel_a] >= dac_a), .i_halt(halt), .o_converter_power(pwr_a),
        .o_input_select(sel_a), .o_dac_code(dac_a), .o_sample(smp_a));
    adcc_device i_adcc_device_b (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_b.dev),
        .i_comparator(LVL[sel_b] >= dac_b), .i_halt(halt), .o_converter_power(pwr_b),
        .o_input_select(sel_b), .o_dac_code(dac_b), .o_sample());
    adcc_host #(.SETTLE_CYCLES(SETTLE)) i_adcc_host (.i_clock(i_clock), .i_rst(i_rst),
        .bus(bus_a.cpu), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_addr(cmd_addr),
        .i_cmd_data(cmd_data), .i_halt(halt), .o_cmd_ready(cmd_ready),
        .o_result_valid(res_valid), .o_result(res), .o_settled(settled));
    adcc_bus_sva i_adcc_bus_sva (.i_clock(i_clock), .i_rst(i_rst), .addr(bus_a.addr),
        .wr(bus_a.wr), .rd(bus_a.rd), .wdata(bus_a.wdata), .rdata(bus_a.rdata));

    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(inout int k);
        @(negedge i_clock);
        k++;
        if (k > 3000) begin
            fail_count++;
            $display("ERROR %0t: wait ran out", $time);
            complete_run();
        end
    endtask : tick
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus_b.wr <= 1'b1;
        bus_b.addr <= a;
        bus_b.wdata <= d;
        @(posedge i_clock);
        bus_b.wr <= 1'b0;
    endtask : bw
    task automatic br(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        bus_b.rd <= 1'b1;
        bus_b.addr <= a;
        @(posedge i_clock);
        bus_b.rd <= 1'b0;
        @(negedge i_clock);
        d = bus_b.rdata;
    endtask : br
    task automatic brc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        br(a, d);
        check({2'b00, d}, {2'b00, e});
    endtask : brc
    task automatic hc(input adcc_cmd_t c, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        do tick(k); while (cmd_ready !== 1'b1);
        @(posedge i_clock);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge i_clock);
        cmd_valid <= 1'b0;
        if (c != ADCC_CMD_WRITE) begin
            do tick(k); while (res_valid !== 1'b1);
            r = res;
        end
    endtask : hc
    task automatic sample_len(output int l);
        int k;
        k = 0;
        l = 0;
        do tick(k); while (smp_a !== 1'b0);
        do tick(k); while (smp_a !== 1'b1);
        do tick(l); while (smp_a === 1'b1);
    endtask : sample_len

    ////////////////////////////////////////////////////////////
    initial begin
        bus_b.addr = 8'h00;
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        bus_b.wdata = 8'h00;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        brc(CSR, 8'h00);
        brc(UPR, 8'h00);
        brc(DRL, 8'h00);
        bw(DRL, 8'hFF);
        brc(DRL, 8'h08);
        bw(UPR, 8'hA5);
        brc(UPR, 8'h00);
        brc(8'h37, 8'h00);
        bw(CSR, 8'h38);
        brc(CSR, 8'h20);
        n = 0;
        do begin
            br(CSR, v);
            tick(n);
        end while (v[ADCC_EOC_BIT] !== 1'b1);
        brc(DRL, 8'h0B);
        brc(UPR, 8'hFF);
        brc(CSR, 8'h20);
        brc(UPR, 8'hFF);
        bw(CSR, 8'h01);
        repeat (400) @(posedge i_clock);
        brc(CSR, 8'h01);
        check({9'h000, pwr_b}, 10'h000);
        check(dac_b, 10'h000);
        for (int ch = 0; ch < 7; ch++) begin
            slow = (ch % 3 == 2);
            spd = (ch % 3 == 1) || (slow && ch[0]);
            div = slow ? 4 : (spd ? 1 : 2);
            hc(ADCC_CMD_WRITE, DRL, {4'h0, slow, 3'h0});
            hc(ADCC_CMD_WRITE, CSR, {1'b0, spd, 1'b1, 2'b00, 3'(ch)});
            repeat (3) hc(ADCC_CMD_READ10, 8'h00, 8'h00);
            check(r, LVL[ch]);
            hc(ADCC_CMD_READ, CSR, 8'h00);
            check(r, {3'b000, spd, 1'b1, 2'b00, 3'(ch)});
            sample_len(len);
            check(10'(len), 10'(ADCC_SAMPLE_TICKS * div));
            check({7'h00, sel_a}, 10'(ch));
        end
        hc(ADCC_CMD_READ8, 8'h00, 8'h00);
        check(r, {2'b00, LVL[6][9:2]});
        hc(ADCC_CMD_READ, 8'h40, 8'h00);
        check(r, 10'h000);
        @(posedge i_clock);
        halt <= 1'b1;
        repeat (4) @(negedge i_clock);
        check({9'h000, pwr_a}, 10'h000);
        check({9'h000, settled}, 10'h000);
        @(posedge i_clock);
        halt <= 1'b0;
        n = 0;
        do tick(n); while (settled !== 1'b1);
        check({9'h000, n >= SETTLE}, 10'h001);
        repeat (2) hc(ADCC_CMD_READ10, 8'h00, 8'h00);
        check(r, LVL[6]);
        check({9'h000, pwr_a}, 10'h001);
        complete_run();
    end
endmodule : adc_control_result_logic_test

`default_nettype wire
